/* logic/owg_guard.sv */
/*
  Oscillator watchdog and overtemperature guard of a dual laser driver.
  Assumes a byte-wide register port decoded from the serial host interface,
  with one-cycle read and write strobes on clk; pins are asynchronous.
*/
// Summary of operation
// - Oscillator silent longer than the limit sets the oscillator fault flag.
// - Oscillator fault flag is sticky, read-only, cleared when status is read.
// - Oscillator fault drives the error pin unless its mask bit is one.
// - Oscillator inject bit forces the fault flag, reported per mask.
// - Eight-bit temperature reading, one degree per count, read-only.
// - Stand-alone: overtemperature raises fault, error pin, both channels off.
// - Stand-alone: fault held until both enable pins low; pin high re-enables.
// - Host mode: overtemperature sets flag, disables channels, asserts error pin.
// - Host mode: flag held until read; enable pin cycling re-enables channel.
// - Overtemperature threshold is a fixed constant.
// - Host mode: overtemperature inject holds fault until inject is cleared.
// - Error pin shows any set and unmasked status bit.
// - Host mode pin high enables registers; low selects stand-alone pins.
`timescale 1ns/100ps
`default_nettype none

module owg_guard
  import owg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = OSC_TIMEOUT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              osc_activity,
  input  wire logic [DATA_W-1:0] temp_code,
  input  wire logic              host_mode_pin,
  input  wire logic              chan1_enable_pin,
  input  wire logic              chan2_enable_pin,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  output var  logic              reg_rvalid,
  output var  logic              error_out_n_o,
  output var  logic              error_out_n_oe_n,
  output var  logic              chan1_drive,
  output var  logic              chan2_drive
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] temp_s1;
  logic [DATA_W-1:0] chip_temperature;
  logic [2:0]        pin_s1;
  logic [2:0]        pin_s2;
  logic              host_mode;
  logic              chan1_pin;
  logic              chan2_pin;
  logic              osc_dead;
  logic              osc_fail_flag;
  logic              overtemp_flag;
  logic              osc_fail_mask;
  logic              overtemp_inject;
  logic              osc_fail_inject;
  logic              chan1_lock;
  logic              chan2_lock;
  logic              status_read;
  logic              ctrl_write;
  logic              osc_set;
  logic              ovt_set;
  logic              err_now;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Temperature code changes slowly, so a per-bit sync is tolerated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_s1          <= RESET_BYTE;
      chip_temperature <= RESET_BYTE;
      pin_s1           <= '0;
      pin_s2           <= '0;
    end else begin
      temp_s1          <= temp_code;
      chip_temperature <= temp_s1;
      pin_s1           <= {host_mode_pin, chan2_enable_pin, chan1_enable_pin};
      pin_s2           <= pin_s1;
    end
  end

  assign host_mode = pin_s2[2];
  assign chan2_pin = pin_s2[1];
  assign chan1_pin = pin_s2[0];

  owg_osc_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_osc_watchdog (
    .clk          (clk),
    .rst_n        (rst_n),
    .osc_activity (osc_activity),
    .osc_dead     (osc_dead)
  );

  // ----------------------------------------------------------------------
  // Register access, only with the host interface enabled
  // ----------------------------------------------------------------------
  assign status_read = host_mode && reg_rd && (reg_addr == ADDR_STATUS);
  assign ctrl_write  = host_mode && reg_wr && (reg_addr == ADDR_FAULT_CTRL);

  // Fault control register; injects count only in host mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_fail_mask   <= RESET_BIT;
      overtemp_inject <= RESET_BIT;
      osc_fail_inject <= RESET_BIT;
    end else if (ctrl_write) begin
      osc_fail_mask   <= reg_wdata[OSC_MASK_BIT];
      overtemp_inject <= reg_wdata[OVT_INJECT_BIT];
      osc_fail_inject <= reg_wdata[OSC_INJECT_BIT];
    end
  end

  // Read data path; one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= RESET_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= host_mode && reg_rd;
      reg_rdata  <= RESET_BYTE;
      if (host_mode && reg_rd) begin
        unique case (reg_addr)
          ADDR_STATUS: begin
            reg_rdata[OSC_FAIL_BIT] <= osc_fail_flag;
            reg_rdata[OVERTEMP_BIT] <= overtemp_flag;
          end
          ADDR_TEMPERATURE: begin
            reg_rdata <= chip_temperature;
          end
          ADDR_FAULT_CTRL: begin
            reg_rdata[OSC_MASK_BIT]   <= osc_fail_mask;
            reg_rdata[OVT_INJECT_BIT] <= overtemp_inject;
            reg_rdata[OSC_INJECT_BIT] <= osc_fail_inject;
          end
          default: begin
            reg_rdata <= RESET_BYTE;         // Unmapped reads as zero
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky fault flags; a pending set always beats a clear
  // ----------------------------------------------------------------------
  assign osc_set = osc_dead || (host_mode && osc_fail_inject);
  // Threshold is a package constant, no register reaches it
  assign ovt_set = (chip_temperature > TEMP_LIMIT) || (host_mode && overtemp_inject);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_fail_flag <= RESET_BIT;
    end else if (osc_set) begin
      osc_fail_flag <= 1'b1;
    end else if (status_read) begin
      osc_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_flag <= RESET_BIT;
    end else if (ovt_set) begin
      overtemp_flag <= 1'b1;
    end else if (host_mode ? status_read : (!chan1_pin && !chan2_pin)) begin
      overtemp_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Channel lockout; a channel restarts only after its pin went low
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_lock <= 1'b0;
      chan2_lock <= 1'b0;
    end else if (ovt_set) begin
      chan1_lock <= 1'b1;
      chan2_lock <= 1'b1;
    end else begin
      chan1_lock <= chan1_lock && chan1_pin;
      chan2_lock <= chan2_lock && chan2_pin;
    end
  end

  // Flag gates too, so a stand-alone fault keeps both channels dark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_drive <= 1'b0;
      chan2_drive <= 1'b0;
    end else begin
      chan1_drive <= chan1_pin && !chan1_lock && !overtemp_flag && !ovt_set;
      chan2_drive <= chan2_pin && !chan2_lock && !overtemp_flag && !ovt_set;
    end
  end

  // ----------------------------------------------------------------------
  // Open-drain error pin, pulled low while an unmasked fault pends
  // ----------------------------------------------------------------------
  assign err_now = (osc_fail_flag && !osc_fail_mask) || overtemp_flag;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_out_n_o    <= 1'b0;
      error_out_n_oe_n <= 1'b1;
    end else begin
      error_out_n_o    <= 1'b0;
      error_out_n_oe_n <= !err_now;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_osc_timeout_flag: assert property (@(posedge clk) disable iff (!rst_n)
    osc_dead |=> osc_fail_flag)
    else $error("oscillator timeout did not set the fault flag");

  chk_osc_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (status_read && !osc_set) |=> !osc_fail_flag)
    else $error("oscillator fault flag not cleared by status read");

  chk_osc_mask_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (osc_fail_flag && osc_fail_mask && !overtemp_flag) |=> error_out_n_oe_n)
    else $error("masked oscillator fault reached the error pin");

  chk_osc_inject_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_write && reg_wdata[OSC_INJECT_BIT]) ##1 host_mode |=> osc_fail_flag)
    else $error("oscillator inject did not set the fault flag");

  chk_temp_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (host_mode && reg_rd && reg_addr == ADDR_TEMPERATURE) |=> reg_rvalid && reg_rdata == $past(chip_temperature))
    else $error("temperature read returned wrong value");

  chk_ovt_chan_off: assert property (@(posedge clk) disable iff (!rst_n)
    (chip_temperature > TEMP_LIMIT) |=> overtemp_flag && !chan1_drive && !chan2_drive ##1 !error_out_n_oe_n)
    else $error("overtemperature did not stop channels or flag error");

  chk_alone_pin_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (!host_mode && !chan1_pin && !chan2_pin && !ovt_set) |=> !overtemp_flag)
    else $error("stand-alone fault not cleared with both pins low");

  chk_ovt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (host_mode && overtemp_flag && !status_read) |=> overtemp_flag)
    else $error("overtemperature flag dropped without a read");

  chk_ovt_inject_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (host_mode && overtemp_inject) [*2] |-> overtemp_flag && !chan1_drive)
    else $error("overtemperature inject did not hold the fault");

  chk_alone_no_regs: assert property (@(posedge clk) disable iff (!rst_n)
    (!host_mode && reg_rd) |=> !reg_rvalid)
    else $error("register read answered in stand-alone mode");

  chk_lock_needs_low: assert property (@(posedge clk) disable iff (!rst_n)
    (chan1_lock && chan1_pin) |=> !chan1_drive)
    else $error("locked channel restarted without pin going low");

endmodule : owg_guard

`default_nettype wire

/* logic/owg_pkg.sv */
/*
  Shared constants of the oscillator watchdog and overtemperature guard:
  register offsets, field positions, reset values and timing figures.
  Assumes a single 125 MHz system clock on the consuming modules.
*/
`default_nettype none

package owg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W            = 6;
  localparam int unsigned DATA_W            = 8;
  localparam logic [5:0]  ADDR_STATUS       = 6'h00;
  localparam logic [5:0]  ADDR_TEMPERATURE  = 6'h02;
  localparam logic [5:0]  ADDR_FAULT_CTRL   = 6'h1D;

  // Field positions
  localparam int unsigned OSC_FAIL_BIT      = 6;
  localparam int unsigned OVERTEMP_BIT      = 3;
  localparam int unsigned OSC_MASK_BIT      = 0;
  localparam int unsigned OVT_INJECT_BIT    = 4;
  localparam int unsigned OSC_INJECT_BIT    = 7;

  // Reset values
  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam logic        RESET_BIT         = 1'b0;

  // ----------------------------------------------------------------------
  // Timing and thresholds
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 8;
  // Longest allowed silence of the oscillator before a fault
  localparam int unsigned OSC_TIMEOUT_NS    = 20000;
  // Least time, so round up
  localparam int unsigned OSC_TIMEOUT_CYC   = (OSC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Fixed overtemperature limit, not writable by software
  localparam logic [7:0]  TEMP_LIMIT        = 8'hA5;

endpackage : owg_pkg

`default_nettype wire

/* logic/owg_osc_watchdog.sv */
/*
  Activity watchdog for the internal oscillator.
  Assumes osc_activity toggles asynchronously to clk; it is synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

module owg_osc_watchdog
  import owg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = OSC_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic osc_activity,
  output var  logic osc_dead
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

  logic          sync1;
  logic          sync2;
  logic          sync3;
  logic [CW-1:0] silent_count;

  // ----------------------------------------------------------------------
  // Input synchroniser; only sync2 and sync3 feed the edge detector
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= osc_activity;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ----------------------------------------------------------------------
  // Silence counter, restarted by any edge, saturates at the limit
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      silent_count <= '0;
      osc_dead     <= 1'b0;
    end else if (sync2 != sync3) begin
      silent_count <= '0;
      osc_dead     <= 1'b0;
    end else if (silent_count == CW'(TIMEOUT_CYC)) begin
      osc_dead     <= 1'b1;                 // Level held while silent
    end else begin
      silent_count <= silent_count + CW'(1);
    end
  end

endmodule : owg_osc_watchdog

`default_nettype wire

/* test/owg_host_model.sv */
/*
  Host controller model: register access, channel enable pins, pulled-up error line.
  Assumes the guard's byte register port on clk and an open-drain error pin.
*/
`timescale 1ns/100ps
`default_nettype none

module owg_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  input  wire logic       error_out_n_o,
  input  wire logic       error_out_n_oe_n,
  output var  logic [5:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic       chan1_enable_pin,
  output var  logic       chan2_enable_pin,
  output var  logic       error_level
);
  // Pull-up wins while the guard releases the line
  assign error_level = error_out_n_oe_n ? 1'b1 : error_out_n_o;

  // Quiet bus, both channels requested
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chan1_enable_pin = 1'b1;
    chan2_enable_pin = 1'b1;
  end

  // Read strobe one cycle; answer taken one cycle later
  task automatic rd(input logic [5:0] a, output logic v, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a; // Released address never shows a stale value
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Both pins low long enough to pass the sync, then high again
  task automatic cycle_enables();
    @(posedge clk);
    chan1_enable_pin <= 1'b0;
    chan2_enable_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chan1_enable_pin <= 1'b1;
    chan2_enable_pin <= 1'b1;
  endtask
endmodule // owg_host_model

`default_nettype wire

/* test/owg_guard_bench.sv */
/*
  Self-checking bench of the guard against an integer model of its flags.
  Assumes the host model beside it and a shortened oscillator timeout.
*/
`timescale 1ns/100ps
`default_nettype none

module owg_guard_bench;
  localparam int TO = 20;
  logic clk, rst_n, osc_activity, osc_run, host_mode_pin;
  logic [7:0] temp_code, reg_wdata, reg_rdata;
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, eo, eoe, ch1, ch2, en1, en2, err_level;
  int err_count = 0, n_tests = 0, cyc = 0, seed = 50249;
  int m_osc = 0, m_ovt = 0, m_osc_src = 0, m_ovt_src = 0, m_ctrl = 0;

  owg_guard #(.TIMEOUT_CYC(TO)) owg_guard_inst (.clk(clk), .rst_n(rst_n),
    .osc_activity(osc_activity), .temp_code(temp_code), .host_mode_pin(host_mode_pin),
    .chan1_enable_pin(en1), .chan2_enable_pin(en2), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .error_out_n_o(eo), .error_out_n_oe_n(eoe),
    .chan1_drive(ch1), .chan2_drive(ch2));
  owg_host_model owg_host_model_inst (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .error_out_n_o(eo), .error_out_n_oe_n(eoe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .chan1_enable_pin(en1), .chan2_enable_pin(en2), .error_level(err_level));

  // ----------------------------------------------------------------
  // Clock, oscillator activity, hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (osc_run) osc_activity <= ~osc_activity;
  // Run needs about 200 cycles; generous margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      $display("MISMATCH t=%0t timeout, run did not finish", $time);
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Model view of each register; unmapped places read zero
  function automatic logic [7:0] exp_rd(input logic [5:0] a);
    case (a)
      6'h00: exp_rd = 8'(m_osc * 64 + m_ovt * 8);
      6'h02: exp_rd = temp_code;
      6'h1D: exp_rd = 8'(m_ctrl) & 8'h91;
      default: exp_rd = 8'h00;
    endcase
  endfunction

  // Status read clears flags unless their cause is still present
  task automatic rchk(input logic [5:0] a);
    logic v;
    logic [7:0] d;
    owg_host_model_inst.rd(a, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, exp_rd(a));
    if (a == 6'h00) begin
      m_osc = m_osc_src;
      m_ovt = m_ovt_src;
    end
  endtask

  task automatic wctl(input logic [7:0] d);
    owg_host_model_inst.wr(6'h1D, d);
    m_ctrl = d;
  endtask

  task automatic drv(input logic [1:0] e);
    chk({6'h00, ch1, ch2}, {6'h00, e});
  endtask

  initial begin
    logic v;
    logic [7:0] d;
    rst_n = 1'b0;
    osc_activity = 1'b0;
    osc_run = 1'b1;
    temp_code = 8'h20;
    host_mode_pin = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wt(4);
    rchk(6'h1D);
    rchk(6'h00);
    chk(err_level, 1'b1);
    drv(2'b11);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) temp_code <= 8'($unsigned($random(seed)) % 166);
      wt(4);
      rchk(6'h02);
    end
    rchk(6'h05);
    // Injected oscillator fault, masked and unmasked
    wctl(8'h80);
    m_osc = 1;
    m_osc_src = 1;
    wt(4);
    chk(err_level, 1'b0);
    wctl(8'h81);
    wt(4);
    chk(err_level, 1'b1);
    rchk(6'h1D);
    rchk(6'h00);
    wctl(8'h00);
    m_osc_src = 0;
    wt(3);
    chk(err_level, 1'b0);
    rchk(6'h00);
    rchk(6'h00);
    wt(3);
    chk(err_level, 1'b1);
    // Oscillator goes silent past the limit
    osc_run <= 1'b0;
    wt(TO + 12);
    m_osc = 1;
    chk(err_level, 1'b0);
    osc_run <= 1'b1;
    wt(6);
    rchk(6'h00);
    rchk(6'h00);
    // Threshold edge, then real overtemperature in host mode
    @(posedge clk) temp_code <= 8'hA5;
    wt(5);
    drv(2'b11);
    chk(err_level, 1'b1);
    @(posedge clk) temp_code <= 8'hA6;
    wt(5);
    m_ovt = 1;
    drv(2'b00);
    chk(err_level, 1'b0);
    @(posedge clk) temp_code <= 8'h20;
    wt(5);
    drv(2'b00);
    rchk(6'h00);
    wt(3);
    chk(err_level, 1'b1);
    owg_host_model_inst.cycle_enables();
    wt(5);
    drv(2'b11);
    // Injected overtemperature survives reads until withdrawn
    wctl(8'h10);
    m_ovt = 1;
    m_ovt_src = 1;
    wt(4);
    drv(2'b00);
    rchk(6'h00);
    rchk(6'h00);
    wctl(8'h00);
    m_ovt_src = 0;
    wt(3);
    rchk(6'h00);
    rchk(6'h00);
    owg_host_model_inst.cycle_enables();
    wt(5);
    drv(2'b11);
    // Stand-alone: register port shut, pins clear the fault
    @(posedge clk) host_mode_pin <= 1'b0;
    wt(4);
    owg_host_model_inst.rd(6'h00, v, d);
    chk({7'h00, v}, 8'h00);
    chk(d, 8'h00);
    @(posedge clk) temp_code <= 8'hA6;
    wt(5);
    chk(err_level, 1'b0);
    drv(2'b00);
    @(posedge clk) temp_code <= 8'h20;
    wt(5);
    chk(err_level, 1'b0);
    owg_host_model_inst.cycle_enables();
    wt(5);
    chk(err_level, 1'b1);
    drv(2'b11);
    report_and_stop();
  end
endmodule // owg_guard_bench

`default_nettype wire
